// file: shared/bsf_pkg.sv
// bsf_pkg: opcodes, states, status bit positions, register map and reset
// values of the bit/shift/flag datapath.
// assumes one core clock and a decoder that hands over one op per handshake.
package bsf_pkg;

  // status_flag_register bit positions
  localparam logic [2:0] SR_C = 3'h0;
  localparam logic [2:0] SR_Z = 3'h1;
  localparam logic [2:0] SR_N = 3'h2;
  localparam logic [2:0] SR_V = 3'h3;
  localparam logic [2:0] SR_S = 3'h4;
  localparam logic [2:0] SR_H = 3'h5;
  localparam logic [2:0] SR_T = 3'h6;
  localparam logic [2:0] SR_I = 3'h7;

  // values after reset
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam logic [7:0] RESULT_RST  = 8'h00;

  // wishbone byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_RESULT = 4'h8;

  // ctrl register fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;

  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_IO_HIGH    = 5'h01,
    OP_IO_LOW     = 5'h02,
    OP_SHL        = 5'h03,
    OP_SHR        = 5'h04,
    OP_RLC        = 5'h05,
    OP_RRC        = 5'h06,
    OP_SAR        = 5'h07,
    OP_SWAP       = 5'h08,
    OP_SBIT_HIGH  = 5'h09,
    OP_SBIT_LOW   = 5'h0a,
    OP_BIT_TO_T   = 5'h0b,
    OP_T_TO_BIT   = 5'h0c,
    OP_C_HIGH     = 5'h0d,
    OP_C_LOW      = 5'h0e,
    OP_N_HIGH     = 5'h0f,
    OP_N_LOW      = 5'h10,
    OP_Z_HIGH     = 5'h11,
    OP_Z_LOW      = 5'h12,
    OP_IRQ_ON     = 5'h13,
    OP_IRQ_OFF    = 5'h14,
    OP_S_HIGH     = 5'h15,
    OP_S_LOW      = 5'h16,
    OP_H_HIGH     = 5'h17,
    OP_H_LOW      = 5'h18
  } bsf_op_e;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_IO_WR = 1'b1
  } bsf_state_e;

endpackage

// file: src/bsf_shift_unit.sv
// bsf_shift_unit: combinational shift, rotate and nibble swap with flags.
// assumes the caller only uses the outputs for shift-class opcodes.
module bsf_shift_unit
  import bsf_pkg::*;
(
  // operation
  input  wire bsf_op_e    op,
  input  wire logic [7:0] din,
  input  wire logic [7:0] flags_in,
  // result
  output logic      [7:0] dout,
  output logic      [7:0] flags_out
);

  // z, n, c and v follow the result; s, h, t and i are passed through
  function automatic logic [7:0] upd_flags(input logic [7:0] s,
                                           input logic [7:0] res,
                                           input logic       c);
    logic [7:0] f;
    f       = s;
    f[SR_Z] = (res == 8'h00);
    f[SR_N] = res[7];
    f[SR_C] = c;
    f[SR_V] = res[7] ^ c;
    return f;
  endfunction

  always_comb begin
    dout      = din;
    flags_out = flags_in;
    case (op)
      OP_SHL: begin
        dout      = {din[6:0], 1'b0};
        flags_out = upd_flags(flags_in, dout, din[7]);
      end
      OP_SHR: begin
        dout      = {1'b0, din[7:1]};
        flags_out = upd_flags(flags_in, dout, din[0]);
      end
      OP_RLC: begin
        dout      = {din[6:0], flags_in[SR_C]};
        flags_out = upd_flags(flags_in, dout, din[7]);
      end
      OP_RRC: begin
        dout      = {flags_in[SR_C], din[7:1]};
        flags_out = upd_flags(flags_in, dout, din[0]);
      end
      OP_SAR: begin
        dout      = {din[7], din[7:1]};
        flags_out = upd_flags(flags_in, dout, din[0]);
      end
      OP_SWAP: begin
        dout      = {din[3:0], din[7:4]};
      end
      default: begin
        dout      = din;
      end
    endcase
  end

endmodule

// file: src/bsf_wb_slave.sv
// bsf_wb_slave: classic wishbone slave for the datapath's three registers.
// assumes a master that holds its request until it samples ack high.
module bsf_wb_slave
  import bsf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // register side
  input  wire logic [7:0]  rd_status,
  input  wire logic [7:0]  rd_ctrl,
  input  wire logic [7:0]  rd_result,
  output logic             wr_status,
  output logic             wr_ctrl
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bsf_wb_s;

  bsf_wb_s s_q;
  bsf_wb_s s_d;
  logic    commit;

  // writes land on the edge that the master samples ack
  assign commit    = wb_cyc_i & wb_stb_i & wb_we_i & s_q.ack & wb_sel_i[0];
  assign wr_status = commit & (wb_adr_i == OFS_STATUS);
  assign wr_ctrl   = commit & (wb_adr_i == OFS_CTRL);
  assign wb_ack_o  = s_q.ack;
  assign wb_dat_o  = s_q.dat;

  always_comb begin
    s_d     = s_q;
    s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.dat = 32'h0000_0000;
    // unmapped offsets still ack, reading zero
    if (wb_adr_i == OFS_STATUS) begin
      s_d.dat[7:0] = rd_status;
    end else if (wb_adr_i == OFS_CTRL) begin
      s_d.dat[7:0] = rd_ctrl;
    end else if (wb_adr_i == OFS_RESULT) begin
      s_d.dat[7:0] = rd_result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: src/bsf_datapath.sv
// bsf_datapath: bit, shift, rotate, swap and status flag ops of an 8-bit
// core, holding the status flag register.
// assumes the decoder supplies the destination value on op_rd_data and
// writes rd_wdata back when rd_we pulses; the i/o space answers a read
// with io_rdata in the same cycle as io_re.
module bsf_datapath
  import bsf_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // op from decoder
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic [4:0]  op_code,
  input  wire logic [7:0]  op_rd_data,
  input  wire logic [2:0]  op_bit,
  input  wire logic [5:0]  op_io_addr,
  // register file write back
  output logic             rd_we,
  output logic      [7:0]  rd_wdata,
  // i/o space
  output logic      [5:0]  io_addr,
  output logic             io_re,
  input  wire logic [7:0]  io_rdata,
  output logic             io_we,
  output logic      [7:0]  io_wdata,
  // status_flag_register to the core
  output logic      [7:0]  status_flags,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  typedef struct packed {
    bsf_state_e  state;
    logic [7:0]  flags;
    logic        en;
    logic        rd_we;
    logic [7:0]  rd_wdata;
    logic [7:0]  result;
    logic [5:0]  io_addr;
    logic        io_re;
    logic        io_we;
    logic [7:0]  io_wdata;
    logic [2:0]  io_bit;
    logic        io_high;
  } bsf_dp_s;

  bsf_dp_s    s_q;
  bsf_dp_s    s_d;
  bsf_op_e    op;
  logic       take;
  logic [7:0] sh_dout;
  logic [7:0] sh_flags;
  logic       wr_status;
  logic       wr_ctrl;
  logic [7:0] ctrl_rd;
  logic       ff_hit;
  logic [2:0] ff_idx;
  logic       ff_val;

  // dedicated single flag ops: {hit, bit index, forced value}
  function automatic logic [4:0] flag_force(input bsf_op_e o);
    case (o)
      OP_C_HIGH:  return {1'b1, SR_C, 1'b1};
      OP_C_LOW:   return {1'b1, SR_C, 1'b0};
      OP_N_HIGH:  return {1'b1, SR_N, 1'b1};
      OP_N_LOW:   return {1'b1, SR_N, 1'b0};
      OP_Z_HIGH:  return {1'b1, SR_Z, 1'b1};
      OP_Z_LOW:   return {1'b1, SR_Z, 1'b0};
      OP_IRQ_ON:  return {1'b1, SR_I, 1'b1};
      OP_IRQ_OFF: return {1'b1, SR_I, 1'b0};
      OP_S_HIGH:  return {1'b1, SR_S, 1'b1};
      OP_S_LOW:   return {1'b1, SR_S, 1'b0};
      OP_H_HIGH:  return {1'b1, SR_H, 1'b1};
      OP_H_LOW:   return {1'b1, SR_H, 1'b0};
      default:    return 5'h00;
    endcase
  endfunction

  // shift-class ops that write rd from the shift unit
  function automatic logic is_shift(input bsf_op_e o);
    return (o == OP_SHL) || (o == OP_SHR) || (o == OP_RLC) ||
           (o == OP_RRC) || (o == OP_SAR) || (o == OP_SWAP);
  endfunction

  assign op                       = bsf_op_e'(op_code);
  assign op_ready                 = (s_q.state == ST_IDLE) & s_q.en;
  assign take                     = op_valid & op_ready;
  assign {ff_hit, ff_idx, ff_val} = flag_force(op);

  assign rd_we        = s_q.rd_we;
  assign rd_wdata     = s_q.rd_wdata;
  assign io_addr      = s_q.io_addr;
  assign io_re        = s_q.io_re;
  assign io_we        = s_q.io_we;
  assign io_wdata     = s_q.io_wdata;
  assign status_flags = s_q.flags;

  always_comb begin
    ctrl_rd                = 8'h00;
    ctrl_rd[CTRL_EN_BIT]   = s_q.en;
    ctrl_rd[CTRL_BUSY_BIT] = (s_q.state != ST_IDLE);
  end

  bsf_shift_unit u_shift (
    .op        (op),
    .din       (op_rd_data),
    .flags_in  (s_q.flags),
    .dout      (sh_dout),
    .flags_out (sh_flags)
  );

  bsf_wb_slave u_wb (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .rd_status (s_q.flags),
    .rd_ctrl   (ctrl_rd),
    .rd_result (s_q.result),
    .wr_status (wr_status),
    .wr_ctrl   (wr_ctrl)
  );

  always_comb begin
    s_d       = s_q;
    s_d.rd_we = 1'b0;
    s_d.io_re = 1'b0;
    s_d.io_we = 1'b0;
    // bus writes first so a same-cycle op update to a flag wins
    if (wr_status) begin
      s_d.flags = wb_dat_i[7:0];
    end
    if (wr_ctrl) begin
      s_d.en = wb_dat_i[CTRL_EN_BIT];
    end
    case (s_q.state)
      ST_IDLE: begin
        if (take) begin
          if (op == OP_IO_HIGH || op == OP_IO_LOW) begin
            s_d.io_addr = op_io_addr;
            s_d.io_re   = 1'b1;
            s_d.io_bit  = op_bit;
            s_d.io_high = (op == OP_IO_HIGH);
            s_d.state   = ST_IO_WR;
          end else if (is_shift(op)) begin
            s_d.rd_we    = 1'b1;
            s_d.rd_wdata = sh_dout;
            s_d.result   = sh_dout;
            // only z, c, n, v move; swap moves none
            s_d.flags    = sh_flags;
          end else if (op == OP_SBIT_HIGH) begin
            s_d.flags[op_bit] = 1'b1;
          end else if (op == OP_SBIT_LOW) begin
            s_d.flags[op_bit] = 1'b0;
          end else if (op == OP_BIT_TO_T) begin
            s_d.flags[SR_T] = op_rd_data[op_bit];
          end else if (op == OP_T_TO_BIT) begin
            s_d.rd_we            = 1'b1;
            s_d.rd_wdata         = op_rd_data;
            s_d.rd_wdata[op_bit] = s_q.flags[SR_T];
            s_d.result           = s_d.rd_wdata;
          end else if (ff_hit) begin
            s_d.flags[ff_idx] = ff_val;
          end
        end
      end
      ST_IO_WR: begin
        // read data arrives now; write goes out next cycle, no flag moves
        s_d.io_we            = 1'b1;
        s_d.io_wdata         = io_rdata;
        s_d.io_wdata[s_q.io_bit] = s_q.io_high;
        s_d.state            = ST_IDLE;
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.state    <= ST_IDLE;
      s_q.flags    <= FLAGS_RST;
      s_q.en       <= CTRL_EN_RST;
      s_q.rd_wdata <= RESULT_RST;
      s_q.result   <= RESULT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // checks

  sequence s_take(bsf_op_e o);
    take && op == o && !wr_status;
  endsequence

  sequence s_io_rmw;
    io_re && !io_we ##1 io_we && !io_re;
  endsequence

  chk_io_two_clk: assert property (
    @(posedge mclk) disable iff (!rst_b)
    take && (op == OP_IO_HIGH || op == OP_IO_LOW) |=> s_io_rmw
  ) else $error("io bit op did not read then write in two clocks");

  chk_io_bit_forced: assert property (
    @(posedge mclk) disable iff (!rst_b)
    io_re ##1 io_we |->
      io_wdata[s_q.io_bit] == s_q.io_high &&
      (io_wdata | (8'h01 << s_q.io_bit)) ==
      ($past(io_rdata) | (8'h01 << s_q.io_bit))
  ) else $error("io write did not force only the addressed bit");

  chk_io_no_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_IO_HIGH) ##1 !wr_status |=> $stable(status_flags)
  ) else $error("io bit op changed a status flag");

  chk_lsl_result: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SHL) |=> rd_we &&
      rd_wdata == {$past(op_rd_data[6:0]), 1'b0} &&
      status_flags[SR_C] == $past(op_rd_data[7]) &&
      status_flags[SR_V] == (rd_wdata[7] ^ status_flags[SR_C]) &&
      status_flags[SR_Z] == (rd_wdata == 8'h00)
  ) else $error("left shift result or flags wrong");

  chk_lsr_result: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SHR) |=> rd_we && rd_wdata[7] == 1'b0 &&
      rd_wdata[6:0] == $past(op_rd_data[7:1]) &&
      status_flags[SR_C] == $past(op_rd_data[0]) && !status_flags[SR_N]
  ) else $error("right shift result or flags wrong");

  chk_rol_carry: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_RLC) |=> rd_wdata[0] == $past(status_flags[SR_C]) &&
      status_flags[SR_C] == $past(op_rd_data[7]) &&
      rd_wdata[7:1] == $past(op_rd_data[6:0])
  ) else $error("rotate left via carry wrong");

  chk_ror_carry: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_RRC) |=> rd_wdata[7] == $past(status_flags[SR_C]) &&
      status_flags[SR_C] == $past(op_rd_data[0]) &&
      status_flags[SR_N] == rd_wdata[7]
  ) else $error("rotate right via carry wrong");

  chk_asr_sign: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SAR) |=> rd_wdata == {$past(op_rd_data[7]),
      $past(op_rd_data[7:1])} && status_flags[SR_C] == $past(op_rd_data[0])
  ) else $error("arithmetic right shift wrong");

  chk_swap_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SWAP) |=> rd_we && $stable(status_flags) &&
      rd_wdata == {$past(op_rd_data[3:0]), $past(op_rd_data[7:4])}
  ) else $error("nibble swap wrong or touched a flag");

  chk_sbit_only: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SBIT_LOW) |=> !status_flags[$past(op_bit)] &&
      ((status_flags ^ $past(status_flags)) &
       ~(8'h01 << $past(op_bit))) == 8'h00
  ) else $error("status bit clear touched another bit");

  chk_t_transfer: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_T_TO_BIT) |=> rd_we &&
      rd_wdata[$past(op_bit)] == $past(status_flags[SR_T])
  ) else $error("transfer flag load wrong");

  chk_flag_force: assert property (
    @(posedge mclk) disable iff (!rst_b)
    take && ff_hit && !wr_status |=>
      status_flags[$past(ff_idx)] == $past(ff_val) &&
      ((status_flags ^ $past(status_flags)) &
       ~(8'h01 << $past(ff_idx))) == 8'h00 && !rd_we
  ) else $error("single flag op wrong or touched another flag");

  chk_others_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    take && is_shift(op) && !wr_status |=>
      status_flags[7:4] == $past(status_flags[7:4])
  ) else $error("shift op changed an unnamed flag");

  chk_sbit_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SBIT_HIGH) |=> status_flags[$past(op_bit)] &&
      ((status_flags ^ $past(status_flags)) &
       ~(8'h01 << $past(op_bit))) == 8'h00 && !rd_we
  ) else $error("status bit set touched another bit");

  chk_io_low_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_IO_LOW) ##1 !wr_status |=> $stable(status_flags)
  ) else $error("io bit clear changed a status flag");

  chk_io_busy: assert property (
    @(posedge mclk) disable iff (!rst_b)
    io_re |-> !op_ready && !io_we
  ) else $error("op could be taken during the io read cycle");

  chk_t_store: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_BIT_TO_T) |=> !rd_we &&
      status_flags[SR_T] == $past(op_rd_data[op_bit]) &&
      ((status_flags ^ $past(status_flags)) & ~(8'h01 << SR_T)) == 8'h00
  ) else $error("bit store to transfer flag wrong");

  chk_lsr_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SHR) |=> status_flags[SR_Z] == (rd_wdata == 8'h00) &&
      status_flags[SR_V] == status_flags[SR_C]
  ) else $error("right shift zero or overflow flag wrong");

  chk_rot_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_RLC) |=> status_flags[SR_Z] == (rd_wdata == 8'h00) &&
      status_flags[SR_N] == rd_wdata[7] &&
      status_flags[SR_V] == (rd_wdata[7] ^ status_flags[SR_C])
  ) else $error("rotate left flags wrong");

  chk_ror_rest: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_RRC) |=> rd_we && rd_wdata[6:0] == $past(op_rd_data[7:1]) &&
      status_flags[SR_Z] == (rd_wdata == 8'h00)
  ) else $error("rotate right data or zero flag wrong");

  chk_asr_flags: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_SAR) |=> status_flags[SR_N] == rd_wdata[7] &&
      status_flags[SR_Z] == (rd_wdata == 8'h00) &&
      status_flags[SR_V] == (rd_wdata[7] ^ status_flags[SR_C])
  ) else $error("arithmetic right shift flags wrong");

  chk_nop_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    s_take(OP_NOP) |=> !rd_we && $stable(status_flags)
  ) else $error("no-op wrote a register or a flag");

endmodule

// file: bench/bsf_io_model.sv
// bsf_io_model: 64-byte i/o space answering the datapath's io strobes.
// assumes io_rdata is wanted in the same cycle as io_re.
module bsf_io_model (
  // clock
  input  wire logic       mclk,
  // i/o strobes
  input  wire logic [5:0] io_addr,
  input  wire logic       io_re,
  input  wire logic       io_we,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [64];

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end

  // outside a read the data is inverted, so a stale byte never looks valid
  assign io_rdata = io_re ? mem[io_addr] : ~mem[io_addr];

  always @(posedge mclk) begin
    if (io_we) begin
      mem[io_addr] <= io_wdata;
    end
  end
endmodule

// file: bench/test_bsf_datapath.sv
// test_bsf_datapath: op sweep, io read-modify-write and bus access.
// assumes bsf_pkg encodings and the io model as the i/o space.
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end

module test_bsf_datapath
  import bsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        op_valid = 1'b0;
  logic        op_ready;
  logic [4:0]  op_code = 5'h00;
  logic [7:0]  op_rd_data = 8'h00;
  logic [2:0]  op_bit = 3'h0;
  logic [5:0]  op_io_addr = 6'h00;
  logic        rd_we;
  logic [7:0]  rd_wdata;
  logic [5:0]  io_addr;
  logic        io_re;
  logic [7:0]  io_rdata;
  logic        io_we;
  logic [7:0]  io_wdata;
  logic [7:0]  status_flags;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [31:0] rd_dump;
  logic [7:0]  exp_s = 8'h00;
  int          failures = 0;
  int          checked = 0;

  bsf_datapath i_dut (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_rd_data(op_rd_data),
    .op_bit(op_bit), .op_io_addr(op_io_addr), .rd_we(rd_we),
    .rd_wdata(rd_wdata), .io_addr(io_addr), .io_re(io_re),
    .io_rdata(io_rdata), .io_we(io_we), .io_wdata(io_wdata),
    .status_flags(status_flags), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  bsf_io_model i_io (.mclk(mclk), .io_addr(io_addr), .io_re(io_re),
    .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata));

  initial begin
    forever begin
      #10 mclk = ~mclk;
    end
  end

  // expected result, write-back flag and status after one op
  function automatic void model(input logic [4:0] c, input logic [7:0] x,
      input logic [2:0] b, inout logic [7:0] s, output logic [7:0] r,
      output logic w);
    logic [7:0] m;
    m = 8'h01 << b;
    r = x;
    w = (c >= OP_SHL && c <= OP_SWAP) || c == OP_T_TO_BIT;
    case (c)
      OP_SHL: r = {x[6:0], 1'b0};
      OP_SHR: r = {1'b0, x[7:1]};
      OP_RLC: r = {x[6:0], s[SR_C]};
      OP_RRC: r = {s[SR_C], x[7:1]};
      OP_SAR: r = {x[7], x[7:1]};
      OP_SWAP: r = {x[3:0], x[7:4]};
      OP_SBIT_HIGH: s[b] = 1'b1;
      OP_SBIT_LOW: s[b] = 1'b0;
      OP_BIT_TO_T: s[SR_T] = x[b];
      OP_T_TO_BIT: r = s[SR_T] ? (x | m) : (x & ~m);
      OP_C_HIGH, OP_C_LOW: s[SR_C] = (c == OP_C_HIGH);
      OP_N_HIGH, OP_N_LOW: s[SR_N] = (c == OP_N_HIGH);
      OP_Z_HIGH, OP_Z_LOW: s[SR_Z] = (c == OP_Z_HIGH);
      OP_IRQ_ON, OP_IRQ_OFF: s[SR_I] = (c == OP_IRQ_ON);
      OP_S_HIGH, OP_S_LOW: s[SR_S] = (c == OP_S_HIGH);
      OP_H_HIGH, OP_H_LOW: s[SR_H] = (c == OP_H_HIGH);
      default: r = x;
    endcase
    if (c >= OP_SHL && c <= OP_SAR) begin
      s[SR_C] = (c == OP_SHL || c == OP_RLC) ? x[7] : x[0];
      s[SR_Z] = (r == 8'h00);
      s[SR_N] = r[7];
      s[SR_V] = s[SR_N] ^ s[SR_C];
    end
  endfunction

  task automatic stop_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ends on the edge that samples ack high; data is taken at that edge,
  // before the slave's own update lands; only the watchdog ends a hang
  task automatic wb_wait(output logic [31:0] d);
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
  endtask

  task automatic wb_xfer(input logic we, input logic [3:0] a,
      input logic [31:0] wd, input logic [3:0] sl, output logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= wd;
    wb_wait(d);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wb_read(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    wb_xfer(1'b0, a, 32'h0, 4'hf, d);
    `CHK("wb_dat_o", e, d)
  endtask

  task automatic set_status(input logic [7:0] v, input logic [3:0] sl);
    logic [31:0] d;
    wb_xfer(1'b1, OFS_STATUS, {24'h0, v}, sl, d);
    if (sl[0]) exp_s = v;
    `CHK("status_flags", exp_s, status_flags)
  endtask

  // offers an op and returns at the edge that takes it, op_valid still up
  task automatic issue(input logic [4:0] c, input logic [7:0] x,
      input logic [2:0] b, input logic [5:0] a);
    int n = 0;
    op_valid   <= 1'b1;
    op_code    <= c;
    op_rd_data <= x;
    op_bit     <= b;
    op_io_addr <= a;
    do begin
      @(negedge mclk);
      n++;
    end while (op_ready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    @(posedge mclk);
  endtask

  task automatic run_op(input logic [4:0] c, input logic [7:0] x,
      input logic [2:0] b);
    logic [7:0] r;
    logic       w;
    model(c, x, b, exp_s, r, w);
    issue(c, x, b, 6'h00);
    op_valid <= 1'b0;
    @(negedge mclk);
    `CHK("rd_we", w, rd_we)
    if (w) `CHK("rd_wdata", r, rd_wdata)
    `CHK("status_flags", exp_s, status_flags)
    @(posedge mclk);
    if (w) wb_read(OFS_RESULT, {24'h0, r});
  endtask

  localparam logic [7:0] STARTS [3] = '{8'h00, 8'hff, 8'ha5};
  localparam logic [7:0] DATA [3] = '{8'h81, 8'h80, 8'h01};

  initial begin
    logic [4:0] c;
    logic [5:0] a;
    logic [2:0] b;
    logic [7:0] e;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("status_flags", FLAGS_RST, status_flags)
    `CHK("op_ready", 1'b1, op_ready)
    @(posedge mclk);
    wb_read(OFS_CTRL, 32'h1);
    wb_read(OFS_RESULT, {24'h0, RESULT_RST});
    wb_read(4'hc, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 3; k++) begin
        for (int i = 3; i <= 24; i++) begin
          set_status(STARTS[s], 4'hf);
          run_op(5'(i), DATA[k], 3'(i + k * 3));
        end
      end
    end
    $display("test op sweep done");
    set_status(8'h00, 4'hf);
    run_op(OP_NOP, 8'h55, 3'h2);
    run_op(5'h1f, 8'h55, 3'h2);
    issue(OP_C_HIGH, 8'h00, 3'h0, 6'h00);
    issue(OP_Z_HIGH, 8'h00, 3'h0, 6'h00);
    issue(OP_IRQ_ON, 8'h00, 3'h0, 6'h00);
    op_valid <= 1'b0;
    @(negedge mclk);
    `CHK("status_flags", 8'h83, status_flags)
    @(posedge mclk);
    exp_s = 8'h83;
    set_status(8'h00, 4'he);
    $display("test back to back done");
    for (int k = 0; k < 4; k++) begin
      c = k[0] ? OP_IO_LOW : OP_IO_HIGH;
      b = k[1] ? 3'h7 : 3'h0;
      a = 6'(k * 9 + 3);
      e = k[0] ? (i_io.mem[a] & ~(8'h01 << b)) : (i_io.mem[a] | (8'h01 << b));
      issue(c, 8'h00, b, a);
      op_valid <= 1'b0;
      @(negedge mclk);
      `CHK("io_re", 1'b1, io_re)
      `CHK("io_addr", a, io_addr)
      `CHK("io_we", 1'b0, io_we)
      `CHK("op_ready", 1'b0, op_ready)
      @(negedge mclk);
      `CHK("io_we", 1'b1, io_we)
      `CHK("io_wdata", e, io_wdata)
      @(negedge mclk);
      `CHK("io_mem", e, i_io.mem[a])
      `CHK("status_flags", exp_s, status_flags)
      @(posedge mclk);
    end
    $display("test io bits done");
    wb_xfer(1'b1, OFS_CTRL, 32'h0, 4'hf, rd_dump);
    @(negedge mclk);
    `CHK("op_ready", 1'b0, op_ready)
    @(posedge mclk);
    wb_read(OFS_CTRL, 32'h0);
    wb_xfer(1'b1, OFS_CTRL, 32'h1, 4'hf, rd_dump);
    @(negedge mclk);
    `CHK("op_ready", 1'b1, op_ready)
    @(posedge mclk);
    $display("test enable done");
    stop_test();
  end

  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule
